// *** design/esi_pkg.sv ***
package esi_pkg;
  // register indices on the control bus
  localparam logic [7:0] ESI_OFS_STATUS = 8'h09;
  localparam logic [7:0] ESI_OFS_INC_HI = 8'h0a;
  localparam logic [7:0] ESI_OFS_INC_MID = 8'h0b;
  localparam logic [7:0] ESI_OFS_INC_LO = 8'h0c;
  // status field positions
  localparam int ESI_ST_SYNC_OK = 7;
  localparam int ESI_ST_FRAME_LOCK = 6;
  localparam int ESI_ST_CC2_OK = 5;
  localparam int ESI_ST_CC1_OK = 4;
  localparam int ESI_ST_FIELD_LSB = 1;
  localparam int ESI_ST_JUMP = 0;
  // reset values and caption queue depth
  localparam logic ESI_RST_SYNC_OK = 1'b1;
  localparam logic ESI_RST_CC_OK = 1'b1;
  localparam logic [2:0] ESI_RST_FIELD = 3'h0;
  localparam logic [1:0] ESI_CC_DEPTH = 2'h2;
  localparam logic [23:0] ESI_RST_PHASE = 24'h00_0000;
  // hard-wired increments per standard
  localparam logic [23:0] ESI_INC_NTSC_M = 24'h21_F07C;
  localparam logic [23:0] ESI_INC_PAL_BGHIN = 24'h2A_098B;
  localparam logic [23:0] ESI_INC_PAL_N = 24'h21_F694;
  localparam logic [23:0] ESI_INC_PAL_M = 24'h21_E6F0;

  typedef enum logic [1:0] {
    ESI_STD_NTSC_M,
    ESI_STD_PAL_BGHIN,
    ESI_STD_PAL_N,
    ESI_STD_PAL_M
  } esi_std_e;

  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } esi_reg_req_s;

  typedef struct packed {
    logic decode_valid;
    logic decode_err;
    logic slave_mode;
    logic ref_locked;
    logic [2:0] field_id;
    logic jump_busy;
  } esi_video_s;

  typedef struct packed {
    logic pair_written;
    logic pair_encoded;
  } esi_cc_s;
endpackage

// *** design/esi_status_inc.sv ***
`timescale 1ns/1ps
module esi_status_inc (
  input wire logic ref_clk,
  input wire logic rstn,
  input esi_pkg::esi_reg_req_s reg_req,
  output logic [7:0] reg_rdata,
  input esi_pkg::esi_video_s video,
  input esi_pkg::esi_cc_s cc_field1,
  input esi_pkg::esi_cc_s cc_field2,
  input wire logic inc_select,
  input wire logic soft_reset,
  input esi_pkg::esi_std_e standard,
  output logic cc_field1_access_ok,
  output logic cc_field2_access_ok,
  output logic [23:0] synth_phase,
  output logic [7:0] synth_sine
);
  import esi_pkg::*;

  // pending pair count; a write and an encode in one cycle cancel out
  function automatic logic [1:0] cc_next(input logic [1:0] cnt, input esi_cc_s ev);
    logic [1:0] n;
    n = cnt;
    if (ev.pair_written && !ev.pair_encoded && cnt != ESI_CC_DEPTH) begin
      n = cnt + 2'h1;
    end else if (ev.pair_encoded && !ev.pair_written && cnt != 2'h0) begin
      n = cnt - 2'h1;
    end
    return n;
  endfunction

  // quarter-wave table, 16 steps; symmetry rebuilds the full cycle
  function automatic logic [6:0] quarter_sine(input logic [3:0] idx);
    logic [6:0] v;
    v = 7'h00;
    case (idx)
      4'h0: v = 7'h06;
      4'h1: v = 7'h13;
      4'h2: v = 7'h1F;
      4'h3: v = 7'h2B;
      4'h4: v = 7'h37;
      4'h5: v = 7'h42;
      4'h6: v = 7'h4C;
      4'h7: v = 7'h56;
      4'h8: v = 7'h5F;
      4'h9: v = 7'h67;
      4'hA: v = 7'h6D;
      4'hB: v = 7'h73;
      4'hC: v = 7'h78;
      4'hD: v = 7'h7B;
      4'hE: v = 7'h7E;
      default: v = 7'h7F;
    endcase
    return v;
  endfunction

  function automatic logic [23:0] hardwired_inc(input esi_std_e std);
    logic [23:0] v;
    v = ESI_INC_NTSC_M;
    case (std)
      ESI_STD_PAL_BGHIN: v = ESI_INC_PAL_BGHIN;
      ESI_STD_PAL_N: v = ESI_INC_PAL_N;
      ESI_STD_PAL_M: v = ESI_INC_PAL_M;
      default: v = ESI_INC_NTSC_M;
    endcase
    return v;
  endfunction

  logic sync_ok_q, sync_ok_d;
  logic last_err_q, last_err_d;
  logic lock_q, lock_d;
  logic [2:0] field_q, field_d;
  logic jump_q, jump_d;
  logic [1:0] cc1_cnt_q, cc1_cnt_d;
  logic [1:0] cc2_cnt_q, cc2_cnt_d;
  logic [7:0] inc_hi_q, inc_hi_d;
  logic [7:0] inc_mid_q, inc_mid_d;
  logic [7:0] inc_lo_q, inc_lo_d;
  logic use_prog_q, use_prog_d;
  logic [23:0] prog_inc_q, prog_inc_d;
  logic [23:0] phase_q, phase_d;
  logic [7:0] sine_q, sine_d;
  logic [7:0] rdata_q, rdata_d;
  logic [23:0] active_inc;
  logic [7:0] status_byte;

  // video status sampling
  always_comb begin
    sync_ok_d = sync_ok_q;
    last_err_d = last_err_q;
    if (video.decode_valid) begin
      last_err_d = video.decode_err;
      sync_ok_d = !(video.decode_err && last_err_q);
    end
    lock_d = video.slave_mode && video.ref_locked;
    field_d = video.field_id;
    jump_d = video.jump_busy;
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sync_ok_q <= ESI_RST_SYNC_OK;
      last_err_q <= 1'b0;
      lock_q <= 1'b0;
      field_q <= ESI_RST_FIELD;
      jump_q <= 1'b0;
    end else begin
      sync_ok_q <= sync_ok_d;
      last_err_q <= last_err_d;
      lock_q <= lock_d;
      field_q <= field_d;
      jump_q <= jump_d;
    end
  end

  // caption buffer occupancy, one count per field
  always_comb begin
    cc1_cnt_d = cc_next(cc1_cnt_q, cc_field1);
    cc2_cnt_d = cc_next(cc2_cnt_q, cc_field2);
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cc1_cnt_q <= 2'h0;
      cc2_cnt_q <= 2'h0;
    end else begin
      cc1_cnt_q <= cc1_cnt_d;
      cc2_cnt_q <= cc2_cnt_d;
    end
  end

  // flag drops only with two pairs queued, so a single write per frame keeps it high
  assign cc_field1_access_ok = (cc1_cnt_q != ESI_CC_DEPTH);
  assign cc_field2_access_ok = (cc2_cnt_q != ESI_CC_DEPTH);

  // increment byte registers; deliberately outside every reset
  always_comb begin
    inc_hi_d = inc_hi_q;
    inc_mid_d = inc_mid_q;
    inc_lo_d = inc_lo_q;
    if (reg_req.wr) begin
      case (reg_req.addr)
        ESI_OFS_INC_HI: inc_hi_d = reg_req.wdata;
        ESI_OFS_INC_MID: inc_mid_d = reg_req.wdata;
        ESI_OFS_INC_LO: inc_lo_d = reg_req.wdata;
        default: inc_hi_d = inc_hi_q;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    inc_hi_q <= inc_hi_d;
    inc_mid_q <= inc_mid_d;
    inc_lo_q <= inc_lo_d;
  end

  // increment source latched only at soft reset
  always_comb begin
    use_prog_d = use_prog_q;
    prog_inc_d = prog_inc_q;
    if (soft_reset) begin
      use_prog_d = inc_select;
      prog_inc_d = {inc_hi_q, inc_mid_q, inc_lo_q};
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      use_prog_q <= 1'b0;
      prog_inc_q <= ESI_RST_PHASE;
    end else begin
      use_prog_q <= use_prog_d;
      prog_inc_q <= prog_inc_d;
    end
  end

  // hard-wired value follows the standard live, as it is not held in a register
  assign active_inc = use_prog_q ? prog_inc_q : hardwired_inc(standard);

  // phase accumulator and sine lookup
  always_comb begin
    logic [6:0] q;
    logic [3:0] idx;
    q = 7'h00;
    idx = phase_q[21:18];
    phase_d = soft_reset ? ESI_RST_PHASE : phase_q + active_inc;
    if (phase_q[22]) begin
      idx = ~phase_q[21:18];
    end
    q = quarter_sine(idx);
    sine_d = phase_q[23] ? (8'h80 - {1'b0, q}) : (8'h80 + {1'b0, q});
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      phase_q <= ESI_RST_PHASE;
      sine_q <= 8'h80;
    end else begin
      phase_q <= phase_d;
      sine_q <= sine_d;
    end
  end

  assign synth_phase = phase_q;
  assign synth_sine = sine_q;

  // status byte assembly
  always_comb begin
    status_byte = 8'h00;
    status_byte[ESI_ST_SYNC_OK] = sync_ok_q;
    status_byte[ESI_ST_FRAME_LOCK] = lock_q;
    status_byte[ESI_ST_CC2_OK] = cc_field2_access_ok;
    status_byte[ESI_ST_CC1_OK] = cc_field1_access_ok;
    status_byte[ESI_ST_FIELD_LSB +: 3] = field_q;
    status_byte[ESI_ST_JUMP] = jump_q;
  end

  // read data registered; unmapped offsets read zero
  always_comb begin
    case (reg_req.addr)
      ESI_OFS_STATUS: rdata_d = status_byte;
      ESI_OFS_INC_HI: rdata_d = inc_hi_q;
      ESI_OFS_INC_MID: rdata_d = inc_mid_q;
      ESI_OFS_INC_LO: rdata_d = inc_lo_q;
      default: rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

  // checks
  sequence s_two_errors;
    (video.decode_valid && video.decode_err) ##[1:9]
      (video.decode_valid && video.decode_err && last_err_q);
  endsequence

  property p_sync_bad;
    @(posedge ref_clk) disable iff (!rstn)
      (video.decode_valid && video.decode_err && last_err_q) |=> !sync_ok_q;
  endproperty
  a_sync_bad: assert property (p_sync_bad) else $error("sync ok not cleared");

  property p_sync_good;
    @(posedge ref_clk) disable iff (!rstn)
      (video.decode_valid && !video.decode_err) |=> sync_ok_q;
  endproperty
  a_sync_good: assert property (p_sync_good) else $error("sync ok not set");

  property p_lock;
    @(posedge ref_clk) disable iff (!rstn)
      rstn |=> (lock_q == ($past(video.slave_mode) && $past(video.ref_locked)));
  endproperty
  a_lock: assert property (p_lock) else $error("frame lock mismatch");

  property p_cc2_full;
    @(posedge ref_clk) disable iff (!rstn)
      (cc2_cnt_q == 2'h1 && cc_field2.pair_written && !cc_field2.pair_encoded)
        |=> !cc_field2_access_ok;
  endproperty
  a_cc2_full: assert property (p_cc2_full) else $error("cc2 flag not cleared");

  property p_cc2_free;
    @(posedge ref_clk) disable iff (!rstn)
      (!cc_field2_access_ok && cc_field2.pair_encoded && !cc_field2.pair_written)
        |=> cc_field2_access_ok ##0 (cc2_cnt_q == 2'h1);
  endproperty
  a_cc2_free: assert property (p_cc2_free) else $error("cc2 flag not restored");

  property p_cc1_full;
    @(posedge ref_clk) disable iff (!rstn)
      (cc1_cnt_q == 2'h1 && cc_field1.pair_written && !cc_field1.pair_encoded)
        |=> !cc_field1_access_ok ##1 (!cc_field1_access_ok || $past(cc_field1.pair_encoded));
  endproperty
  a_cc1_full: assert property (p_cc1_full) else $error("cc1 flag wrong");

  property p_cc_reset;
    @(posedge ref_clk) $rose(rstn) |-> cc_field1_access_ok && cc_field2_access_ok;
  endproperty
  a_cc_reset: assert property (p_cc_reset) else $error("cc flags low after reset");

  property p_field;
    @(posedge ref_clk) disable iff (!rstn)
      rstn |=> (status_byte[ESI_ST_FIELD_LSB +: 3] == $past(video.field_id));
  endproperty
  a_field: assert property (p_field) else $error("field number mismatch");

  property p_prog_inc;
    @(posedge ref_clk) disable iff (!rstn)
      (soft_reset && inc_select) |=> ##1
        (phase_q == $past(prog_inc_q)) && use_prog_q;
  endproperty
  a_prog_inc: assert property (p_prog_inc) else $error("programmed increment unused");

  property p_hard_inc;
    @(posedge ref_clk) disable iff (!rstn)
      (rstn && !use_prog_q && !soft_reset) |=> (phase_q == $past(phase_q) + $past(active_inc))
        ##0 ($past(active_inc) == hardwired_inc($past(standard)));
  endproperty
  a_hard_inc: assert property (p_hard_inc) else $error("hard-wired increment not used");

  property p_jump;
    @(posedge ref_clk) disable iff (!rstn)
      video.jump_busy[*2] |-> ##1 status_byte[ESI_ST_JUMP];
  endproperty
  a_jump: assert property (p_jump) else $error("jump bit not set");

  property p_two_err;
    @(posedge ref_clk) disable iff (!rstn)
      s_two_errors |=> !sync_ok_q;
  endproperty
  a_two_err: assert property (p_two_err) else $error("double error missed");
endmodule

// *** dv/esi_ctrl_model.sv ***
`timescale 1ns/1ps
// controller side of the register port, one request per wr or rd call, three per load_inc
module esi_ctrl_model (
  input wire logic ref_clk,
  input wire logic [7:0] rdata,
  output esi_pkg::esi_reg_req_s req
);
  import esi_pkg::*;
  initial req = '0;
  // single-cycle strobe, address and data launched together
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    req <= '{wr: 1'b1, addr: a, wdata: d};
    @(posedge ref_clk);
    req.wr <= 1'b0;
  endtask
  // read data is registered, so wait two edges past the address;
  // stale write data is inverted so it never looks meaningful
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    req <= '{wr: 1'b0, addr: a, wdata: ~req.wdata};
    repeat (2) @(posedge ref_clk);
    #1 d = rdata;
  endtask
  // all three bytes go in before any selecting soft reset
  task automatic load_inc(input logic [23:0] v);
    wr(ESI_OFS_INC_HI, v[23:16]);
    wr(ESI_OFS_INC_MID, v[15:8]);
    wr(ESI_OFS_INC_LO, v[7:0]);
  endtask
endmodule

// *** dv/esi_status_inc_tb.sv ***
`timescale 1ns/1ps
module esi_status_inc_tb;
  import esi_pkg::*;
  logic ref_clk, rstn, inc_select, soft_reset, ok1, ok2;
  logic [7:0] rdata, sine, rb;
  logic [23:0] phase, inc, p0;
  esi_reg_req_s req;
  esi_video_s video;
  esi_cc_s cc[2];
  esi_std_e standard;
  int miscompares, checks;

  esi_status_inc uut (.ref_clk(ref_clk), .rstn(rstn), .reg_req(req),
    .reg_rdata(rdata), .video(video), .cc_field1(cc[0]), .cc_field2(cc[1]),
    .inc_select(inc_select), .soft_reset(soft_reset), .standard(standard),
    .cc_field1_access_ok(ok1), .cc_field2_access_ok(ok2),
    .synth_phase(phase), .synth_sine(sine));
  esi_ctrl_model ctrl (.ref_clk(ref_clk), .rdata(rdata), .req(req));

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  task automatic chk(input string what, input logic [23:0] exp,
                     input logic [23:0] got);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic conclude();
    if (miscompares == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  function automatic logic [23:0] hw_inc(esi_std_e s);
    case (s)
      ESI_STD_NTSC_M: return ESI_INC_NTSC_M;
      ESI_STD_PAL_BGHIN: return ESI_INC_PAL_BGHIN;
      ESI_STD_PAL_N: return ESI_INC_PAL_N;
      default: return ESI_INC_PAL_M;
    endcase
  endfunction

  // expected status with sync and both caption flags good
  function automatic logic [7:0] st_exp();
    return {3'b111, 1'b1, video.field_id, video.jump_busy} &
      {1'b1, ~(video.slave_mode & video.ref_locked), 6'h3f} ^
      {1'b0, 1'b1, 6'h00};
  endfunction

  // one-cycle caption event on field f, flag settled on return
  task automatic cc_ev(input int f, input bit enc, input logic exp);
    @(posedge ref_clk);
    if (enc) cc[f].pair_encoded <= 1'b1;
    else cc[f].pair_written <= 1'b1;
    @(posedge ref_clk);
    cc[f] <= '0;
    #1 chk("cc flag", exp, f ? ok2 : ok1);
  endtask

  task automatic sync_ev(input bit err, input logic exp);
    @(posedge ref_clk);
    video.decode_valid <= 1'b1;
    video.decode_err <= err;
    @(posedge ref_clk);
    video.decode_valid <= 1'b0;
    ctrl.rd(ESI_OFS_STATUS, rb);
    chk("sync ok", exp, rb[ESI_ST_SYNC_OK]);
  endtask

  // phase step over one clock must equal the active increment
  task automatic rate(input logic [23:0] exp);
    @(posedge ref_clk);
    #1 p0 = phase;
    @(posedge ref_clk);
    #1 chk("phase step", exp, phase - p0);
  endtask

  task automatic rd_inc();
    for (int i = 0; i < 3; i++) begin
      ctrl.rd(8'(ESI_OFS_INC_HI + i), rb);
      chk("inc byte", inc[23 - 8 * i -: 8], rb);
    end
  endtask

  initial begin
    #100_000;
    miscompares++;
    conclude();
  end

  initial begin
    rstn = 1'b0;
    inc_select = 1'b0;
    soft_reset = 1'b0;
    video = '0;
    cc[0] = '0;
    cc[1] = '0;
    standard = ESI_STD_NTSC_M;
    miscompares = 0;
    checks = 0;
    void'($urandom(32'h5c5e));
    repeat (4) @(posedge ref_clk);
    #1 chk("sine", 8'h80, sine);
    chk("cc flags", 2'b11, {ok2, ok1});
    @(posedge ref_clk) rstn <= 1'b1;
    ctrl.rd(ESI_OFS_STATUS, rb);
    chk("status", 8'hb0, rb);
    ctrl.wr(ESI_OFS_STATUS, 8'h00);
    ctrl.rd(ESI_OFS_STATUS, rb);
    chk("status ro", 8'hb0, rb);
    ctrl.rd(8'h55, rb);
    chk("unmapped", 8'h00, rb);
    // first pass is the awkward one: locked but not slave, field 1
    for (int i = 0; i < 9; i++) begin
      @(posedge ref_clk);
      video <= esi_video_s'({2'b00, i == 0 ? 6'h13 : 6'($urandom)});
      ctrl.rd(ESI_OFS_STATUS, rb);
      chk("status", st_exp(), rb);
    end
    sync_ev(1'b1, 1'b1);
    sync_ev(1'b1, 1'b0);
    sync_ev(1'b0, 1'b1);
    sync_ev(1'b1, 1'b1);
    for (int f = 0; f < 2; f++) begin
      cc_ev(f, 1'b0, 1'b1);
      cc_ev(f, 1'b0, 1'b0);
      ctrl.rd(ESI_OFS_STATUS, rb);
      chk("cc status", 1'b0, rb[ESI_ST_CC1_OK + f]);
      cc_ev(f, 1'b0, 1'b0);
      cc_ev(f, 1'b1, 1'b1);
      cc_ev(f, 1'b1, 1'b1);
    end
    inc = 24'($urandom);
    ctrl.load_inc(inc);
    rd_inc();
    @(posedge ref_clk) inc_select <= 1'b1;
    rate(hw_inc(standard));
    @(posedge ref_clk) soft_reset <= 1'b1;
    @(posedge ref_clk) soft_reset <= 1'b0;
    #1 chk("phase", 24'h00_0000, phase);
    rate(inc);
    @(posedge ref_clk) begin
      soft_reset <= 1'b1;
      inc_select <= 1'b0;
    end
    @(posedge ref_clk) soft_reset <= 1'b0;
    for (int s = 0; s < 4; s++) begin
      @(posedge ref_clk) standard <= esi_std_e'(s);
      rate(hw_inc(esi_std_e'(s)));
    end
    // hard reset with the select level still high must not pick it up
    @(posedge ref_clk) begin
      rstn <= 1'b0;
      inc_select <= 1'b1;
    end
    @(posedge ref_clk) rstn <= 1'b1;
    rate(hw_inc(standard));
    rd_inc();
    conclude();
  end
endmodule
